// ### rtl/tps_timer.sv
// Purpose: 8-bit timer/counter with a scaler shared with the watchdog
// Assumes: Core issues at most one register access per clock on bus_req
// Notes:   Scaler is modelled synchronously; ripple behaviour is not kept
//
// Function
// - Timer mode counts every instruction cycle, no scaler
// - Count write suppresses counting two instruction cycles
// - Counter mode counts pin edges, polarity selectable
// - One 8-bit scaler, timer or watchdog only
// - Assign bit clear gives timer, set watchdog
// - Timer ratios 1:2 to 1:256, scaler hidden
// - Wrap from ff to 00 sets overflow flag
// - Overflow enable bit masks the interrupt request
// - Timer frozen during sleep, no wake
// - Flag sampled each first phase, latency one to four oscillator clocks
// - Pin edge goes through scaler when timer-assigned, then synchronised
// - Synchroniser samples on second and fourth phase
// - Increment three to six oscillator periods after pin
// - Count write clears scaler when timer-assigned
// - Watchdog clear clears scaler when watchdog-assigned

`timescale 1ns/1ps
`default_nettype none

module tps_timer (
   // Clock, reset, enable
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   input  wire logic                 ce,
   // Register port
   input  wire tps_pkg::tps_bus_req_t bus_req,
   output logic [7:0]                rd_data,
   // Core status
   input  wire logic                 sleep,
   input  wire logic                 watchdog_clear_instr,
   input  wire logic                 wdt_tick,
   // External count pin
   input  wire logic                 count_input_pin,
   // Results
   output logic                      overflow_irq,
   output logic                      wdt_timeout,
   output logic [7:0]                timer_config,
   output logic [7:0]                port_a_direction
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   tps_pkg::tps_phase_t  phase;
   tps_pkg::tps_config_t cfg;
   logic [7:0] timer_count;
   logic [7:0] interrupt_control;
   logic [7:0] scaler;
   logic [7:0] next_scaler;
   logic [1:0] inhibit_cnt;
   logic       pin_sync1;
   logic       pin_sync2;
   logic       pin_prev;
   logic       sel_level;
   logic       ext_edge;
   logic       sync_in;
   logic       sync_sample;
   logic       ext_step;
   logic       timer_wr;
   logic       intctl_wr;
   logic       config_wr;
   logic       dira_wr;
   logic       q4_tick;
   logic       scaler_rise;
   logic       wdt_rise;
   logic       timer_step;
   logic       count_step;
   logic       scaler_clr;
   logic [2:0] wdt_bit;

   assign cfg = tps_pkg::tps_config_t'(timer_config);

   // Register write decode
   assign timer_wr  = ce && bus_req.wr && (bus_req.addr == tps_pkg::TPS_ADDR_COUNT);
   assign intctl_wr = ce && bus_req.wr && (bus_req.addr == tps_pkg::TPS_ADDR_INTCTL);
   assign config_wr = ce && bus_req.wr && (bus_req.addr == tps_pkg::TPS_ADDR_CONFIG);
   assign dira_wr   = ce && bus_req.wr && (bus_req.addr == tps_pkg::TPS_ADDR_DIRA);

   ////////////////////////////////////////////////////////////////////////
   // Phase generator, four oscillator clocks per instruction cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         phase <= tps_pkg::TPS_Q1;
      end else if (ce) begin
         phase <= tps_pkg::tps_phase_t'(2'(phase + 2'h1));
      end
   end

   // Instruction clock stops in sleep
   assign q4_tick = ce && (phase == tps_pkg::TPS_Q4) && !sleep;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and edge polarity
   // Edge history starts at the level a low pin shows under reset config
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pin_sync1 <= 1'b0;
         pin_sync2 <= 1'b0;
         pin_prev  <= 1'b1;                      // No false edge after reset
      end else if (ce) begin
         pin_sync1 <= count_input_pin;
         pin_sync2 <= pin_sync1;
         pin_prev  <= sel_level;
      end
   end

   // Falling edges become rising ones when polarity bit is set
   assign sel_level = pin_sync2 ^ cfg.source_edge_select;
   assign ext_edge  = ce && sel_level && !pin_prev;

   ////////////////////////////////////////////////////////////////////////
   // Shared scaler counting
   assign next_scaler = 8'(scaler + 8'h01);
   // Carry out of the selected tap, so a cleared scaler waits a full ratio
   assign scaler_rise = scaler[cfg.scaler_ratio] && !next_scaler[cfg.scaler_ratio];
   assign wdt_bit     = 3'(cfg.scaler_ratio - 3'h1);
   assign wdt_rise    = (cfg.scaler_ratio == 3'h0) ||
                        (scaler[wdt_bit] && !next_scaler[wdt_bit]);
   assign scaler_clr  = (timer_wr && !cfg.scaler_assign) ||
                        (ce && watchdog_clear_instr && cfg.scaler_assign);

   // Scaler serves exactly one user, picked by the assign bit
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         scaler <= 8'h00;
      end else if (scaler_clr) begin
         scaler <= 8'h00;
      end else if (cfg.scaler_assign) begin
         if (ce && wdt_tick) begin
            scaler <= next_scaler;
         end
      end else if (cfg.clock_source_select) begin
         if (ext_edge) begin
            scaler <= next_scaler;
         end
      end else if (q4_tick) begin
         scaler <= next_scaler;
      end
   end

   // Watchdog tick, postscaled when the scaler is its own
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wdt_timeout <= 1'b0;
      end else if (ce) begin
         wdt_timeout <= wdt_tick && (!cfg.scaler_assign || wdt_rise);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter-mode synchroniser sampling on Q2 and Q4
   assign sync_in = cfg.scaler_assign ? sel_level : scaler[cfg.scaler_ratio];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync_sample <= 1'b1;                    // Matches reset-config level
         ext_step    <= 1'b0;
      end else if (ce) begin
         if ((phase == tps_pkg::TPS_Q2) || (phase == tps_pkg::TPS_Q4)) begin
            sync_sample <= sync_in;
            ext_step    <= sync_in && !sync_sample && !sleep &&
                           cfg.clock_source_select;
         end else begin
            ext_step <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Increment sources and write suppression
   assign timer_step = q4_tick && !cfg.clock_source_select &&
                       (cfg.scaler_assign || scaler_rise);
   assign count_step = ce && (timer_step || ext_step) &&
                       (inhibit_cnt == 2'h0) && !sleep;

   // Suppression counts instruction cycle ends after a write
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         inhibit_cnt <= 2'h0;
      end else if (timer_wr) begin
         inhibit_cnt <= tps_pkg::TPS_WR_INHIBIT;
      end else if (ce && (phase == tps_pkg::TPS_Q4) && (inhibit_cnt != 2'h0)) begin
         inhibit_cnt <= 2'(inhibit_cnt - 2'h1);
      end
   end

   // Count register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         timer_count <= tps_pkg::TPS_RST_COUNT;
      end else if (timer_wr) begin
         timer_count <= bus_req.data;
      end else if (count_step) begin
         timer_count <= 8'(timer_count + 8'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt control, overflow set wins over software write
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         interrupt_control <= tps_pkg::TPS_RST_INTCTL;
      end else begin
         if (intctl_wr) begin
            interrupt_control <= bus_req.data;
         end
         if (count_step && (timer_count == 8'hff) && !timer_wr) begin
            interrupt_control[tps_pkg::TPS_OVF_BIT] <= 1'b1;
         end
      end
   end

   // Flag sampled at each first phase
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         overflow_irq <= 1'b0;
      end else if (ce && (phase == tps_pkg::TPS_Q1)) begin
         overflow_irq <= interrupt_control[tps_pkg::TPS_OVF_BIT] &&
                         interrupt_control[tps_pkg::TPS_OVIE_BIT] &&
                         interrupt_control[tps_pkg::TPS_GIE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration and direction registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         timer_config <= tps_pkg::TPS_RST_CONFIG;
      end else if (config_wr) begin
         timer_config <= bus_req.data;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         port_a_direction <= tps_pkg::TPS_RST_DIRA;
      end else if (dira_wr) begin
         port_a_direction <= bus_req.data & tps_pkg::TPS_DIRA_MASK;
      end
   end

   // Read port; scaler itself is not visible
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_data <= 8'h00;
      end else if (ce && bus_req.rd) begin
         unique case (bus_req.addr)
            tps_pkg::TPS_ADDR_COUNT:  rd_data <= timer_count;
            tps_pkg::TPS_ADDR_INTCTL: rd_data <= interrupt_control;
            tps_pkg::TPS_ADDR_CONFIG: rd_data <= timer_config;
            tps_pkg::TPS_ADDR_DIRA:   rd_data <= port_a_direction;
            default:                  rd_data <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence s_write_quiet;
      timer_wr ##1 (!timer_wr)[*4];
   endsequence

   sequence s_pin_edge;
      ce && cfg.clock_source_select && cfg.scaler_assign && !sleep &&
      sel_level && !pin_prev && (inhibit_cnt == 2'h0) && !timer_wr;
   endsequence

   timer_mode_count_a : assert property (
      ce && (phase == tps_pkg::TPS_Q4) && !sleep && !cfg.clock_source_select &&
      cfg.scaler_assign && (inhibit_cnt == 2'h0) && !timer_wr && !config_wr
      |=> timer_count == 8'($past(timer_count) + 8'h01))
      else $error("timer mode missed an increment");

   write_hold_count_a : assert property (
      s_write_quiet |-> timer_count == $past(bus_req.data, 4))
      else $error("count moved soon after a write");

   pin_edge_count_a : assert property (
      s_pin_edge ##1 ce[*4] |-> $past(ext_step, 1) || $past(ext_step, 2) ||
      $past(ext_step, 3))
      else $error("pin edge not counted in time");

   watchdog_owns_scaler_a : assert property (
      ce && cfg.scaler_assign && wdt_tick && !watchdog_clear_instr && !config_wr
      |=> scaler == 8'($past(scaler) + 8'h01))
      else $error("watchdog tick not counted by scaler");

   timer_owns_scaler_a : assert property (
      ce && !cfg.scaler_assign && wdt_tick && !ext_edge && !q4_tick &&
      !timer_wr && !config_wr |=> $stable(scaler) && wdt_timeout)
      else $error("watchdog disturbed timer scaler");

   scaler_ratio_step_a : assert property (
      ce && (phase == tps_pkg::TPS_Q4) && !sleep && !cfg.clock_source_select &&
      !cfg.scaler_assign && (scaler == 8'h00) && (inhibit_cnt == 2'h0) &&
      !timer_wr && !config_wr |=> $stable(timer_count))
      else $error("timer stepped at scaler start");

   overflow_sets_flag_a : assert property (
      count_step && (timer_count == 8'hff) && !timer_wr
      |=> interrupt_control[tps_pkg::TPS_OVF_BIT] && (timer_count == 8'h00))
      else $error("wrap did not set overflow flag");

   irq_mask_gate_a : assert property (
      !interrupt_control[tps_pkg::TPS_OVIE_BIT] && !intctl_wr
      |=> ##[0:4] !overflow_irq)
      else $error("masked overflow raised request");

   sleep_freeze_a : assert property (
      sleep && !timer_wr |=> $stable(timer_count))
      else $error("count moved during sleep");

   irq_first_phase_a : assert property (
      ce && (phase != tps_pkg::TPS_Q1) |=> $stable(overflow_irq))
      else $error("request changed outside first phase");

   sync_phase_only_a : assert property (
      ext_step |-> ($past(phase) == tps_pkg::TPS_Q2) ||
      ($past(phase) == tps_pkg::TPS_Q4))
      else $error("counter step off sample phase");

   write_clear_scaler_a : assert property (
      timer_wr && !cfg.scaler_assign |=> scaler == 8'h00)
      else $error("count write kept scaler");

   wdt_clear_scaler_a : assert property (
      ce && watchdog_clear_instr && cfg.scaler_assign |=> scaler == 8'h00)
      else $error("watchdog clear kept scaler");

endmodule // tps_timer

`default_nettype wire

// ### rtl/tps_pkg.sv
// Purpose: Shared constants and carriers for the 8-bit timer with shared scaler
// Assumes: clk_sys is the oscillator; four clocks make one instruction cycle
// Notes:   Offsets are register-file addresses of the core's data space

package tps_pkg;

   // Register addresses
   localparam logic [8:0] TPS_ADDR_COUNT  = 9'h001;
   localparam logic [8:0] TPS_ADDR_INTCTL = 9'h00b;
   localparam logic [8:0] TPS_ADDR_CONFIG = 9'h081;
   localparam logic [8:0] TPS_ADDR_DIRA   = 9'h085;

   // Values after reset
   localparam logic [7:0] TPS_RST_COUNT   = 8'h00;
   localparam logic [7:0] TPS_RST_INTCTL  = 8'h00;
   localparam logic [7:0] TPS_RST_CONFIG  = 8'hff;
   localparam logic [7:0] TPS_RST_DIRA    = 8'hdf;
   localparam logic [7:0] TPS_DIRA_MASK   = 8'hdf;

   // Interrupt control field positions
   localparam int TPS_GIE_BIT  = 7;
   localparam int TPS_OVIE_BIT = 5;
   localparam int TPS_OVF_BIT  = 2;

   // Instruction cycles of counting suppressed after a count write
   localparam logic [1:0] TPS_WR_INHIBIT = 2'h2;

   // Oscillator phases of one instruction cycle
   typedef enum logic [1:0] {
      TPS_Q1 = 2'b00,
      TPS_Q2 = 2'b01,
      TPS_Q3 = 2'b10,
      TPS_Q4 = 2'b11
   } tps_phase_t;

   // Configuration register layout
   typedef struct packed {
      logic       pullup_off;
      logic       int_edge;
      logic       clock_source_select;
      logic       source_edge_select;
      logic       scaler_assign;
      logic [2:0] scaler_ratio;
   } tps_config_t;

   // One register access from the core
   typedef struct packed {
      logic [8:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] data;
   } tps_bus_req_t;

endpackage

// ### bench/tps_pin_src.sv
// Purpose: External count clock source on the count input pin
// Assumes: Pin is driven push-pull by this source at all times
// Notes:   Pin stands still between bursts; widths stay above two periods
`timescale 1ns/1ps
`default_nettype none

module tps_pin_src (
   // Pin
   output logic count_input_pin
);

   ////////////////////////////////////////////////////////////////////
   // Idle level low from time zero
   initial count_input_pin = 1'b0;

   // Single level change, offset from the clock edges
   task automatic drive(input logic lvl);
      #7 count_input_pin = lvl;
   endtask

   // Burst of whole pulses, each half lasting half_ns
   task automatic pulses(input int n, input int half_ns);
      repeat (n) begin
         #half_ns count_input_pin = 1'b1;
         #half_ns count_input_pin = 1'b0;
      end
   endtask

endmodule // tps_pin_src
`default_nettype wire

// ### bench/testbench.sv
// Purpose: Self-checking bench for the timer with shared scaler
// Assumes: Q1 is the first edge after reset release; counts land on Q4
// Notes:   Count reads are aligned off Q4 edges so differences are exact
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic                  clk_sys = 1'b0;
   logic                  reset = 1'b1;
   logic                  ce = 1'b1;
   tps_pkg::tps_bus_req_t bus_req = '0;
   logic                  sleep = 1'b0;
   logic                  watchdog_clear_instr = 1'b0;
   logic                  wdt_tick = 1'b0;
   wire logic             count_input_pin;
   logic [7:0]            rd_data, timer_config, port_a_direction, a, b;
   logic                  overflow_irq, wdt_timeout;
   int                    err_count = 0, checks_done = 0, cyc = 0, wdt_seen = 0;

   ////////////////////////////////////////////////////////////////////
   // Clock, 40 ns period
   always #20 clk_sys = ~clk_sys;

   // Edges since reset release, and watchdog timeouts seen
   always @(posedge clk_sys) begin
      if (!reset) cyc <= cyc + 1;
      if (wdt_timeout === 1'b1) wdt_seen <= wdt_seen + 1;
   end

   tps_timer uut (
      .clk_sys(clk_sys), .reset(reset), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
      .sleep(sleep), .watchdog_clear_instr(watchdog_clear_instr), .wdt_tick(wdt_tick),
      .count_input_pin(count_input_pin), .overflow_irq(overflow_irq),
      .wdt_timeout(wdt_timeout), .timer_config(timer_config),
      .port_a_direction(port_a_direction)
   );

   tps_pin_src src (.count_input_pin(count_input_pin));

   ////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bus write, taken at the second edge after the call
   task automatic wr(input logic [8:0] ad, input logic [7:0] d);
      @(negedge clk_sys);
      bus_req = '{ad, 1'b1, 1'b0, d};
      @(negedge clk_sys);
      bus_req = '0;
   endtask

   // Bus read, same timing as a write
   task automatic rd(input logic [8:0] ad, output logic [7:0] v);
      @(negedge clk_sys);
      bus_req = '{ad, 1'b0, 1'b1, 8'h00};
      @(negedge clk_sys);
      v = rd_data;
      bus_req = '0;
   endtask

   task automatic rchk(input logic [8:0] ad, input logic [7:0] exp);
      rd(ad, b);
      chk(b, exp);
   endtask

   // Wait so the next access lands two edges after a Q4 edge
   task automatic align();
      while (cyc % 4 != 0) @(negedge clk_sys);
   endtask

   // Watchdog clear instruction strobe
   task automatic clr();
      @(negedge clk_sys);
      watchdog_clear_instr = 1'b1;
      @(negedge clk_sys);
      watchdog_clear_instr = 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(negedge clk_sys);
         wdt_tick = 1'b1;
         @(negedge clk_sys);
         wdt_tick = 1'b0;
      end
      repeat (3) @(negedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Reset values, unmapped place, unimplemented direction bit
   task automatic t_reset();
      chk(timer_config, tps_pkg::TPS_RST_CONFIG);
      chk({7'h00, overflow_irq}, 8'h00);
      rchk(tps_pkg::TPS_ADDR_COUNT, tps_pkg::TPS_RST_COUNT);
      rchk(tps_pkg::TPS_ADDR_INTCTL, tps_pkg::TPS_RST_INTCTL);
      rchk(tps_pkg::TPS_ADDR_CONFIG, 8'hff);
      rchk(tps_pkg::TPS_ADDR_DIRA, 8'hdf);
      wr(9'h002, 8'h55);
      rchk(9'h002, 8'h00);
      wr(tps_pkg::TPS_ADDR_DIRA, 8'hff);
      rchk(tps_pkg::TPS_ADDR_DIRA, 8'hdf);
      chk(port_a_direction, 8'hdf);
      rchk(tps_pkg::TPS_ADDR_COUNT, tps_pkg::TPS_RST_COUNT);
      $display("t_reset done");
   endtask

   // Write inhibit, wrap to zero, flag, mask and latency
   task automatic t_timer();
      wr(tps_pkg::TPS_ADDR_CONFIG, 8'h08);
      align();
      wr(tps_pkg::TPS_ADDR_COUNT, 8'hf8);
      repeat (38) @(negedge clk_sys);
      rchk(tps_pkg::TPS_ADDR_COUNT, 8'h00);
      rchk(tps_pkg::TPS_ADDR_INTCTL, 8'h04);
      wr(tps_pkg::TPS_ADDR_INTCTL, 8'ha4);
      repeat (4) @(negedge clk_sys);
      chk({7'h00, overflow_irq}, 8'h01);
      wr(tps_pkg::TPS_ADDR_INTCTL, 8'h84);
      repeat (4) @(negedge clk_sys);
      chk({7'h00, overflow_irq}, 8'h00);
      rchk(tps_pkg::TPS_ADDR_INTCTL, 8'h84);
      wr(tps_pkg::TPS_ADDR_INTCTL, 8'h00);
      rchk(tps_pkg::TPS_ADDR_INTCTL, 8'h00);
      $display("t_timer done");
   endtask

   // Count frozen while asleep, and while the enable is low
   task automatic t_sleep();
      sleep = 1'b1;
      rd(tps_pkg::TPS_ADDR_COUNT, a);
      repeat (100) @(negedge clk_sys);
      rchk(tps_pkg::TPS_ADDR_COUNT, a);
      sleep = 1'b0;
      rd(tps_pkg::TPS_ADDR_COUNT, a);
      ce = 1'b0;
      repeat (20) @(negedge clk_sys);
      ce = 1'b1;
      repeat (18) @(negedge clk_sys);
      rd(tps_pkg::TPS_ADDR_COUNT, b);
      chk(b - a, 8'h05);
      $display("t_sleep done");
   endtask

   // Watchdog postscaler, clear, and timer left unscaled
   task automatic t_wdt();
      clr();
      wr(tps_pkg::TPS_ADDR_COUNT, 8'h00);
      wr(tps_pkg::TPS_ADDR_CONFIG, 8'h0b);
      repeat (8) @(negedge clk_sys);       // Past the write's inhibit
      align();
      rd(tps_pkg::TPS_ADDR_COUNT, a);
      repeat (38) @(negedge clk_sys);
      rd(tps_pkg::TPS_ADDR_COUNT, b);
      chk(b - a, 8'h0a);
      clr();
      wdt_seen = 0;
      tick(8);
      chk(8'(wdt_seen), 8'h01);
      tick(5);
      clr();
      tick(5);
      chk(8'(wdt_seen), 8'h01);
      tick(3);
      chk(8'(wdt_seen), 8'h02);
      $display("t_wdt done");
   endtask

   // Every ratio code on the timer, then scaler clear on count write
   task automatic t_ratio();
      clr();
      for (int r = 0; r < 8; r++) begin
         wr(tps_pkg::TPS_ADDR_CONFIG, 8'(r));
         align();
         rd(tps_pkg::TPS_ADDR_COUNT, a);
         repeat ((24 << r) - 2) @(negedge clk_sys);
         rd(tps_pkg::TPS_ADDR_COUNT, b);
         chk(b - a, 8'h03);
      end
      wdt_seen = 0;
      tick(2);
      chk(8'(wdt_seen), 8'h02);
      wr(tps_pkg::TPS_ADDR_COUNT, 8'h00);
      repeat (512) @(negedge clk_sys);
      wr(tps_pkg::TPS_ADDR_COUNT, 8'h00);
      repeat (800) @(negedge clk_sys);
      rchk(tps_pkg::TPS_ADDR_COUNT, 8'h00);
      $display("t_ratio done");
   endtask

   // One pin change with a window check on the increment
   task automatic step(input logic lvl, input logic [7:0] inc);
      repeat (8) @(negedge clk_sys);
      rd(tps_pkg::TPS_ADDR_COUNT, a);
      src.drive(lvl);
      rd(tps_pkg::TPS_ADDR_COUNT, b);
      chk(b, a);
      repeat (5) @(negedge clk_sys);
      rd(tps_pkg::TPS_ADDR_COUNT, b);
      chk(b, a + inc);
   endtask

   // Counter mode, both edges, then through the scaler
   task automatic t_counter();
      clr();
      wr(tps_pkg::TPS_ADDR_COUNT, 8'h00);
      wr(tps_pkg::TPS_ADDR_CONFIG, 8'h2f);
      clr();
      wr(tps_pkg::TPS_ADDR_CONFIG, 8'h28);
      step(1'b1, 8'h01);
      step(1'b0, 8'h00);
      wr(tps_pkg::TPS_ADDR_CONFIG, 8'h38);
      step(1'b1, 8'h00);
      step(1'b0, 8'h01);
      clr();
      wr(tps_pkg::TPS_ADDR_CONFIG, 8'h20);
      repeat (8) @(negedge clk_sys);
      rd(tps_pkg::TPS_ADDR_COUNT, a);
      src.pulses(4, 100);
      repeat (10) @(negedge clk_sys);
      rd(tps_pkg::TPS_ADDR_COUNT, b);
      chk(b, a + 8'h02);
      $display("t_counter done");
   endtask

   ////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      t_reset();
      t_timer();
      t_sleep();
      t_wdt();
      t_ratio();
      t_counter();
      end_sim();
   end

   // Hang guard, well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      end_sim();
   end

endmodule // testbench
`default_nettype wire
